//--- ebcs_pkg.sv
/*
  Shared constants for the external bus cycle sequencer: register offsets, field
  positions, reset values and the phase encoding.
  Assumes a 32-bit AHB-Lite register window with one aligned word per register.
*/
package ebcs_pkg;

  // register byte offsets
  localparam logic [7:0] EBCS_OFF_CTRL = 8'h00;
  localparam logic [7:0] EBCS_OFF_STAT = 8'h04;
  localparam logic [7:0] EBCS_OFF_ADDR = 8'h08;
  localparam logic [7:0] EBCS_OFF_WDATA = 8'h0C;
  localparam logic [7:0] EBCS_OFF_RDATA = 8'h10;
  // chip_select_phase_timing_regs, one word per chip select from here
  localparam logic [7:0] EBCS_OFF_TIM0 = 8'h20;

  // control word bit positions
  localparam int EBCS_CTRL_GO = 0;
  localparam int EBCS_CTRL_WRITE = 1;
  localparam int EBCS_CTRL_MUX = 2;
  localparam int EBCS_CTRL_RDY_EN = 3;
  localparam int EBCS_CTRL_RDY_POL = 4;
  localparam int EBCS_CTRL_RDY_ASYNC = 5;
  localparam int EBCS_CTRL_CLK_SEL = 6;
  localparam int EBCS_CTRL_HBE = 7;
  localparam int EBCS_CTRL_CS_LSB = 8;
  localparam int EBCS_CTRL_W = 10;
  localparam logic [EBCS_CTRL_W-1:0] EBCS_CTRL_RST = 10'h000;

  // status word bit positions
  localparam int EBCS_STAT_BUSY = 0;
  localparam int EBCS_STAT_DONE = 1;
  localparam int EBCS_STAT_RDY = 2;
  localparam int EBCS_STAT_PHASE_LSB = 8;

  // timing word fields
  localparam int EBCS_TIM_AB = 0;      // address_setup_phase_len - 1 (1..2)
  localparam int EBCS_TIM_ABX_LSB = 1; // extra setup on window change (0..3)
  localparam int EBCS_TIM_C_LSB = 3;   // command_delay_phase_len (0..3)
  localparam int EBCS_TIM_D = 5;       // write_setup_turnaround_phase_len (0..1)
  localparam int EBCS_TIM_E_LSB = 6;   // access_phase_len - 1 (1..32)
  localparam int EBCS_TIM_F_LSB = 11;  // hold_phase_len (0..3)
  localparam int EBCS_TIM_W = 13;
  // slowest setting of every phase, safe for any attached module
  localparam logic [EBCS_TIM_W-1:0] EBCS_TIM_RST = 13'h1FFF;

  localparam int EBCS_CNT_W = 5;

  typedef enum logic [5:0] {
    EBCS_IDLE = 6'h01,
    EBCS_AB = 6'h02,
    EBCS_C = 6'h04,
    EBCS_D = 6'h08,
    EBCS_E = 6'h10,
    EBCS_F = 6'h20
  } ebcs_phase_t;

endpackage : ebcs_pkg

//--- ebcs_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk; the output moves only when
  the second and third stages agree.
*/
module ebcs_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end

endmodule : ebcs_sync

//--- ebcs_rdcap.sv
/*
  Read data capture register.
  Assumes cap_en is a one-cycle pulse on the edge that ends the read strobe;
  the data bus is stable by protocol then, so it is sampled directly.
*/
module ebcs_rdcap #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cap_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (cap_en) begin
      q <= d;
    end
  end

endmodule : ebcs_rdcap

//--- ebcs_top.sv
/*
  External bus cycle sequencer: AHB-Lite register slave plus the five-phase
  external bus cycle engine with READY handshake and read data capture.
  Assumes hclk is the system clock, the external data bus is sampled on hclk,
  and the READY pin is asynchronous to hclk.
*/
// Chosen here: the AHB-Lite register port and the register addresses.
// Summary of operation
// - each cycle runs address setup, command delay, data setup, access, hold
// - phase lengths come from a timing word per chip select
// - address setup 1..2 cycles, plus 0..3 when chip select changes
// - command delay 0..3 cycles, data setup or turnaround 0..1 cycle
// - access 1..32 cycles, optionally stretched by READY
// - hold phase 0..3 cycles
// - read data captured on the edge that ends the read strobe
// - early address change cannot disturb captured read data
// - system clock routed to the reference clock pin when enabled
// - READY inactive at sample adds a wait cycle, active ends the access
// - READY polarity selectable; asynchronous mode adds one sync stage
module ebcs_top #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int NUM_CS = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [ADDR_W-1:0] ext_addr,
  output logic [DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [DATA_W-1:0] ext_data_in,
  output logic ext_ale,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic [NUM_CS-1:0] ext_cs_n,
  output logic high_byte_enable_n,
  input wire logic ext_ready,
  output logic bus_reference_clock,
  output ebcs_pkg::ebcs_phase_t phase
);
  import ebcs_pkg::*;

  localparam int CS_W = $clog2(NUM_CS);

  // ahb-lite slave, zero wait states
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic wr_en;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      waddr_q <= haddr[7:0];
    end
  end

  assign wr_en = wr_pend_q;

  // software registers
  logic [EBCS_CTRL_W-1:0] ctrl_q;
  logic [ADDR_W-1:0] addr_reg_q;
  logic [DATA_W-1:0] wdata_reg_q;
  logic [EBCS_TIM_W-1:0] tim_q [NUM_CS];
  logic [DATA_W-1:0] rdata_w;
  logic done_q;
  logic go;
  logic [EBCS_CTRL_W-1:0] ctrl_live;
  ebcs_phase_t phase_q;
  ebcs_phase_t phase_d;

  // a go while a cycle runs is dropped; software polls busy first
  assign go = wr_en && (waddr_q == EBCS_OFF_CTRL) && hwdata[EBCS_CTRL_GO]
              && (phase_q == EBCS_IDLE);
  // the go write lands on the same edge, so the cycle takes its settings from that word
  assign ctrl_live = go ? hwdata[EBCS_CTRL_W-1:0] : ctrl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= EBCS_CTRL_RST;
    end else if (wr_en && waddr_q == EBCS_OFF_CTRL) begin
      ctrl_q <= {hwdata[EBCS_CTRL_W-1:1], 1'b0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg_q <= '0;
      wdata_reg_q <= '0;
    end else if (wr_en) begin
      if (waddr_q == EBCS_OFF_ADDR) begin
        addr_reg_q <= hwdata[ADDR_W-1:0];
      end
      if (waddr_q == EBCS_OFF_WDATA) begin
        wdata_reg_q <= hwdata[DATA_W-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi++) begin : g_tim
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tim_q[gi] <= EBCS_TIM_RST;
        end else if (wr_en && waddr_q == EBCS_OFF_TIM0 + 8'(4 * gi)) begin
          tim_q[gi] <= hwdata[EBCS_TIM_W-1:0];
        end
      end
    end
  endgenerate

  // ready path: pin synchroniser, optional extra stage, polarity
  logic rdy_s;
  logic rdy_a_q;
  logic rdy_lvl;
  logic rdy_ok;

  ebcs_sync u_rdy_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din(ext_ready),
    .dout(rdy_s)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_a_q <= 1'b0;
    end else begin
      rdy_a_q <= rdy_s;
    end
  end

  assign rdy_lvl = ctrl_q[EBCS_CTRL_RDY_ASYNC] ? rdy_a_q : rdy_s;
  assign rdy_ok = (rdy_lvl == ctrl_q[EBCS_CTRL_RDY_POL]);

  // cycle parameters: live settings at start, latched copy while running
  logic [EBCS_TIM_W-1:0] cur_tim_q;
  logic [CS_W-1:0] cur_cs_q;
  logic [CS_W-1:0] prev_cs_q;
  logic first_q;
  logic cyc_wr_q;
  logic cyc_mux_q;
  logic cyc_rdy_q;
  logic cyc_hbe_q;
  logic [CS_W-1:0] live_cs;
  logic [EBCS_TIM_W-1:0] live_tim;
  logic win_chg;

  assign live_cs = ctrl_live[EBCS_CTRL_CS_LSB +: CS_W];
  assign live_tim = tim_q[live_cs];
  assign win_chg = first_q || (live_cs != prev_cs_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_tim_q <= EBCS_TIM_RST;
      cur_cs_q <= '0;
      prev_cs_q <= '0;
      first_q <= 1'b1;
      cyc_wr_q <= 1'b0;
      cyc_mux_q <= 1'b0;
      cyc_rdy_q <= 1'b0;
      cyc_hbe_q <= 1'b0;
    end else if (go) begin
      cur_tim_q <= live_tim;
      cur_cs_q <= live_cs;
      prev_cs_q <= live_cs;
      first_q <= 1'b0;
      cyc_wr_q <= ctrl_live[EBCS_CTRL_WRITE];
      cyc_mux_q <= ctrl_live[EBCS_CTRL_MUX];
      cyc_rdy_q <= ctrl_live[EBCS_CTRL_RDY_EN];
      cyc_hbe_q <= ctrl_live[EBCS_CTRL_HBE];
    end
  end

  // phase lengths of the running cycle, each as a count down to zero
  logic [EBCS_CNT_W-1:0] ab_cnt;
  logic [1:0] c_len;
  logic d_len;
  logic [EBCS_CNT_W-1:0] e_cnt;
  logic [1:0] f_len;
  logic [EBCS_CNT_W-1:0] cnt_q;
  logic [EBCS_CNT_W-1:0] cnt_d;
  logic acc_end;

  // an address window change stretches setup by the extra count, up to five cycles
  assign ab_cnt = EBCS_CNT_W'(live_tim[EBCS_TIM_AB])
                + (win_chg ? EBCS_CNT_W'(live_tim[EBCS_TIM_ABX_LSB +: 2]) : '0);
  assign c_len = cur_tim_q[EBCS_TIM_C_LSB +: 2];
  assign d_len = cur_tim_q[EBCS_TIM_D];
  assign e_cnt = cur_tim_q[EBCS_TIM_E_LSB +: 5];
  assign f_len = cur_tim_q[EBCS_TIM_F_LSB +: 2];

  // last access cycle with ready accepted (or not used)
  assign acc_end = (phase_q == EBCS_E) && (cnt_q == '0) && (!cyc_rdy_q || rdy_ok);

  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    case (phase_q)
      EBCS_IDLE: begin
        if (go) begin
          phase_d = EBCS_AB;
          cnt_d = ab_cnt;
        end
      end
      EBCS_AB: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (c_len != 2'd0) begin
          phase_d = EBCS_C;
          cnt_d = EBCS_CNT_W'(c_len - 2'd1);
        end else if (d_len) begin
          phase_d = EBCS_D;
          cnt_d = '0;
        end else begin
          phase_d = EBCS_E;
          cnt_d = e_cnt;
        end
      end
      EBCS_C: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (d_len) begin
          phase_d = EBCS_D;
          cnt_d = '0;
        end else begin
          phase_d = EBCS_E;
          cnt_d = e_cnt;
        end
      end
      EBCS_D: begin
        phase_d = EBCS_E;
        cnt_d = e_cnt;
      end
      EBCS_E: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (!acc_end) begin
          cnt_d = '0; // ready sampled inactive: one more wait cycle
        end else if (f_len != 2'd0) begin
          phase_d = EBCS_F;
          cnt_d = EBCS_CNT_W'(f_len - 2'd1);
        end else begin
          phase_d = EBCS_IDLE;
        end
      end
      EBCS_F: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          phase_d = EBCS_IDLE;
        end
      end
      default: begin
        phase_d = EBCS_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= EBCS_IDLE;
      cnt_q <= '0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
    end
  end

  assign phase = phase_q;

  // read capture on the edge that raises the read strobe; the address may move
  // earlier without effect because only this edge samples the bus
  ebcs_rdcap #(
    .W(DATA_W)
  ) u_rdcap (
    .clk(hclk),
    .rst_n(hresetn),
    .cap_en(acc_end && !cyc_wr_q),
    .d(ext_data_in),
    .q(rdata_w)
  );

  // done is set at cycle end; a new go can only come while idle, after the set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (phase_q != EBCS_IDLE && phase_d == EBCS_IDLE) begin
      done_q <= 1'b1;
    end else if (go) begin
      done_q <= 1'b0;
    end
  end

  // pin outputs, registered from the next phase so they line up with it
  logic act_d;
  logic strobe_d;
  logic [NUM_CS-1:0] cs_dec;

  assign act_d = (phase_d != EBCS_IDLE);
  assign strobe_d = (phase_d == EBCS_D) || (phase_d == EBCS_E);

  always_comb begin
    cs_dec = '1;
    cs_dec[go ? live_cs : cur_cs_q] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ale <= 1'b0;
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      ext_cs_n <= '1;
      high_byte_enable_n <= 1'b1;
    end else begin
      ext_ale <= (phase_d == EBCS_AB);
      ext_rd_n <= !(strobe_d && !(go ? ctrl_live[EBCS_CTRL_WRITE] : cyc_wr_q));
      ext_wr_n <= !(strobe_d && (go ? ctrl_live[EBCS_CTRL_WRITE] : cyc_wr_q));
      ext_cs_n <= act_d ? cs_dec : '1;
      high_byte_enable_n <= !(act_d && (go ? ctrl_live[EBCS_CTRL_HBE] : cyc_hbe_q));
    end
  end

  // address held through the hold phase; data lanes carry address in mux setup,
  // float in the turnaround phase, and carry write data afterwards
  logic mux_d;
  logic wr_d;

  assign mux_d = go ? ctrl_live[EBCS_CTRL_MUX] : cyc_mux_q;
  assign wr_d = go ? ctrl_live[EBCS_CTRL_WRITE] : cyc_wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_addr <= '0;
      ext_data_out <= '0;
      ext_data_oe <= 1'b0;
    end else begin
      if (go) begin
        ext_addr <= addr_reg_q;
      end
      if (mux_d && phase_d == EBCS_AB) begin
        ext_data_out <= addr_reg_q[DATA_W-1:0];
        ext_data_oe <= 1'b1;
      end else if (wr_d && act_d && (!mux_d || phase_d == EBCS_E || phase_d == EBCS_F)) begin
        ext_data_out <= wdata_reg_q;
        ext_data_oe <= 1'b1;
      end else begin
        ext_data_oe <= 1'b0;
      end
    end
  end

  // reference clock: the system clock itself gated by the select bit; the bit
  // is only changed by software, so a single short pulse at switch-over is accepted
  logic clk_sel_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel_q <= 1'b0;
    end else begin
      clk_sel_q <= ctrl_q[EBCS_CTRL_CLK_SEL];
    end
  end

  assign bus_reference_clock = hclk & clk_sel_q;

  // read data chosen in the address phase, presented in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        EBCS_OFF_CTRL: hrdata[EBCS_CTRL_W-1:0] <= ctrl_q;
        EBCS_OFF_STAT: begin
          hrdata[EBCS_STAT_BUSY] <= (phase_q != EBCS_IDLE);
          hrdata[EBCS_STAT_DONE] <= done_q;
          hrdata[EBCS_STAT_RDY] <= rdy_ok;
          hrdata[EBCS_STAT_PHASE_LSB +: 6] <= phase_q;
        end
        EBCS_OFF_ADDR: hrdata[ADDR_W-1:0] <= addr_reg_q;
        EBCS_OFF_WDATA: hrdata[DATA_W-1:0] <= wdata_reg_q;
        EBCS_OFF_RDATA: hrdata[DATA_W-1:0] <= rdata_w;
        default: begin
          for (int i = 0; i < NUM_CS; i++) begin
            if (haddr[7:0] == EBCS_OFF_TIM0 + 8'(4 * i)) begin
              hrdata[EBCS_TIM_W-1:0] <= tim_q[i];
            end
          end
        end
      endcase
    end
  end

endmodule : ebcs_top

//--- ebcs_ext_mem.sv
/*
  Behavioural external memory on the parallel bus, with a READY output.
  Assumes strobes and address come from ebcs_top and a free link clock.
*/
module ebcs_ext_mem (
  input wire logic lclk,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic rdy_hi,
  input int rdy_dly,
  output logic [15:0] ext_data_in,
  output logic ext_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [256];
  logic [15:0] rv = 16'h0;
  logic [15:0] wd = 16'h0;
  logic [7:0] wa = 8'h0;
  logic act = 1'b0;
  wire strb_n = ext_rd_n & ext_wr_n;
  always @(ext_wr_n or ext_addr or ext_data_out) if (!ext_wr_n) begin
    wa = ext_addr[7:0];
    wd = ext_data_out;
  end
  always @(posedge ext_wr_n) mem[wa] = wd;
  always @(ext_rd_n or ext_addr) if (!ext_rd_n) rv = mem[ext_addr[7:0]];
  // released bus shows the inverse, so a late sample never looks right
  assign ext_data_in = ext_rd_n ? ~rv : rv;
  // ready a set time after the strobe, on a link clock edge
  always @(negedge strb_n) begin
    #(rdy_dly);
    @(posedge lclk);
    if (!strb_n) act = 1'b1;
  end
  // dropped with the trailing strobe edge so the next cycle starts not ready
  always @(posedge strb_n) act = 1'b0;
  assign ext_ready = rdy_hi ? act : ~act;
endmodule : ebcs_ext_mem

//--- ebcs_top_sva.sv
/*
  Assertions on the sequencer ports: phase order and lengths, strobes, selects.
  Assumes one clock domain, hclk, with hresetn as its reset.
*/
module ebcs_top_sva
  import ebcs_pkg::*;
#(
  parameter int NUM_CS = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_ale,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [NUM_CS-1:0] ext_cs_n,
  input wire ebcs_pkg::ebcs_phase_t phase
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ab_end;
    phase == EBCS_AB ##1 phase != EBCS_AB;
  endsequence
  sequence s_e_end;
    phase == EBCS_E ##1 phase != EBCS_E;
  endsequence
  sequence s_idle_end;
    phase == EBCS_IDLE ##1 phase != EBCS_IDLE;
  endsequence
  chk_ab_exit: assert property (s_ab_end |-> phase inside {EBCS_C, EBCS_D, EBCS_E})
    else $error("address setup left to a wrong phase");
  chk_e_exit: assert property (s_e_end |-> phase inside {EBCS_F, EBCS_IDLE})
    else $error("access left to a wrong phase");
  chk_start_ab: assert property (s_idle_end |-> phase == EBCS_AB)
    else $error("cycle did not start with address setup");
  chk_ab_max: assert property (phase == EBCS_AB [*5] |=> phase != EBCS_AB)
    else $error("address setup longer than five cycles");
  chk_c_max: assert property (phase == EBCS_C [*3] |=> phase != EBCS_C)
    else $error("command delay longer than three cycles");
  chk_d_max: assert property (phase == EBCS_D |=> phase != EBCS_D)
    else $error("data setup longer than one cycle");
  chk_f_max: assert property (phase == EBCS_F [*3] |=> phase != EBCS_F)
    else $error("hold longer than three cycles");
  chk_ale_ab: assert property (ext_ale == (phase == EBCS_AB))
    else $error("latch strobe outside address setup");
  chk_strobe_de: assert property ((ext_rd_n && ext_wr_n) == !(phase inside {EBCS_D, EBCS_E}))
    else $error("command strobe outside data setup and access");
  chk_cs_one: assert property ($countones(~ext_cs_n) == ((phase == EBCS_IDLE) ? 0 : 1))
    else $error("chip select not one-hot during the cycle");
endmodule : ebcs_top_sva

bind ebcs_top ebcs_top_sva #(.NUM_CS(NUM_CS)) chk_u (.hclk, .hresetn, .ext_ale, .ext_rd_n,
  .ext_wr_n, .ext_cs_n, .phase);

//--- tb_external_bus_cycle_sequencer.sv
/*
  Self-checking bench: AHB-Lite register access, phase lengths, READY and read data.
  Assumes default ebcs_top parameters and the memory model on the far side.
*/
module tb_external_bus_cycle_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import ebcs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, ext_rd_n, ext_wr_n, ext_ale, ext_ready, bus_reference_clock;
  logic hbe_n, data_oe;
  logic [31:0] hrdata, rv;
  logic [23:0] ext_addr;
  logic [15:0] ext_data_out, ext_data_in;
  logic [3:0] ext_cs_n, cs_seen;
  ebcs_phase_t phase;
  logic lclk = 1'b0;
  logic rdy_hi = 1'b1;
  int rdy_dly = 0;
  int fails = 0;
  int samples_checked = 0;
  int pc [6];
  assign hready = hreadyout;
  ebcs_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .ext_addr, .ext_data_out, .ext_data_oe(data_oe), .ext_data_in,
    .ext_ale, .ext_rd_n, .ext_wr_n, .ext_cs_n, .high_byte_enable_n(hbe_n), .ext_ready,
    .bus_reference_clock, .phase);
  ebcs_ext_mem mem_u (.lclk, .ext_addr, .ext_data_out, .ext_rd_n, .ext_wr_n, .rdy_hi,
    .rdy_dly, .ext_data_in, .ext_ready);
  always #25 hclk = ~hclk;
  initial begin
    #13;
    forever #200 lclk = ~lclk;
  end
  task report_and_stop();
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task hang();
    fails++;
    $display("Error %0t: wait ran out", $time);
    report_and_stop();
  endtask : hang
  task edge_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) hang();
      @(posedge hclk);
    end
  endtask : edge_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rv = hrdata;
  endtask : ahb
  // starts one external cycle and counts the cycles spent in each phase
  task run(input logic [9:0] c);
    int n;
    pc = '{default: 0};
    ahb(1'b1, EBCS_OFF_CTRL, {22'h0, c} | 32'h1);
    for (n = 0; n < 300; n++) begin
      #1;
      if (phase === EBCS_IDLE) break;
      for (int k = 0; k < 6; k++) pc[k] += int'(phase[k]);
      if (phase === EBCS_AB) cs_seen = ext_cs_n;
      @(posedge hclk);
    end
    if (n == 300) hang();
  endtask : run
  task phs(input int ab, input int c, input int d, input int e, input int f);
    chk(pc[1], ab);
    chk(pc[2], c);
    chk(pc[3], d);
    chk(pc[4], e);
    chk(pc[5], f);
  endtask : phs
  task t_regs();
    ahb(1'b0, EBCS_OFF_TIM0, 32'h0);
    chk(rv, {19'h0, EBCS_TIM_RST});
    ahb(1'b0, EBCS_OFF_CTRL, 32'h0);
    chk(rv, 32'h0);
    ahb(1'b0, EBCS_OFF_STAT, 32'h0);
    chk(rv & 32'hFFFFFFFB, 32'h100);
    ahb(1'b1, 8'h40, 32'hFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rv, 32'h0);
  endtask : t_regs
  // slowest timing on a fresh window, then the same window again
  task t_timing();
    ahb(1'b1, EBCS_OFF_ADDR, 32'h12);
    ahb(1'b1, EBCS_OFF_WDATA, 32'hBEEF);
    run(10'h102);
    phs(5, 3, 1, 32, 3);
    chk(cs_seen, 32'hD);
    run(10'h102);
    phs(2, 3, 1, 32, 3);
    ahb(1'b0, EBCS_OFF_STAT, 32'h0);
    chk(rv & 32'hFFFFFFFB, 32'h102);
  endtask : t_timing
  task t_readback();
    ahb(1'b1, EBCS_OFF_TIM0 + 8'h8, 32'h0);
    run(10'h200);
    phs(1, 0, 0, 1, 0);
    chk(cs_seen, 32'hB);
    chk(ext_addr, 32'h12);
    chk({hresp, hbe_n, data_oe}, 32'h2);
    ahb(1'b0, EBCS_OFF_RDATA, 32'h0);
    chk(rv, 32'hBEEF);
  endtask : t_readback
  // a slow module: synchronous high, asynchronous low, then READY disabled
  task t_ready();
    rdy_dly = 1000;
    run(10'h218);
    chk(pc[4] inside {[20:36]}, 32'h1);
    rdy_hi <= 1'b0;
    // the pin flips level here; let the synchroniser settle before the next cycle samples
    repeat (8) @(posedge hclk);
    run(10'h228);
    chk(pc[4] inside {[21:37]}, 32'h1);
    run(10'h200);
    chk(pc[4], 32'h1);
    ahb(1'b0, EBCS_OFF_RDATA, 32'h0);
    chk(rv, 32'hBEEF);
  endtask : t_ready
  task t_refclk();
    ahb(1'b1, EBCS_OFF_CTRL, 32'h40);
    @(posedge hclk);
    #10;
    chk(bus_reference_clock, 32'h1);
    #25;
    chk(bus_reference_clock, 32'h0);
    ahb(1'b1, EBCS_OFF_CTRL, 32'h0);
    @(posedge hclk);
    #10;
    chk(bus_reference_clock, 32'h0);
  endtask : t_refclk
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_timing();
    t_readback();
    t_ready();
    t_refclk();
    report_and_stop();
  end
endmodule : tb_external_bus_cycle_sequencer
